// ---- conv_encoder.sv ----
// transmit convolutional encoder: one 4-bit symbol per branch period
// assumes message bits are held valid at the source whenever take pulses
`timescale 1ns/100ps
`default_nettype none
module conv_encoder
  import fano_pkg::*;
#(
  parameter int SYM_CYCLES = SYMBOL_CYCLES
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic two_in,
  input wire logic [1:0] msg_in,
  output logic take_out,
  output logic [3:0] sym_out,
  output logic sym_valid_out
);
  typedef struct packed {
    logic [59:0] shreg;
    logic [12:0] cnt;
    logic [3:0] sym;
    logic valid;
  } enc_t;

  enc_t enc_reg;
  enc_t enc_next;
  logic tick;
  logic [59:0] shifted;

  assign tick = enc_reg.cnt == 13'(SYM_CYCLES - 1);
  assign shifted = shift_fwd(enc_reg.shreg, msg_in, two_in);

  always_comb
  begin
    enc_next = enc_reg;
    enc_next.valid = 1'b0;
    enc_next.cnt = tick ? 13'h0000 : enc_reg.cnt + 13'h0001;
    if (tick)
    begin
      enc_next.shreg = shifted;
      enc_next.sym = symbol_of(shifted, two_in);
      enc_next.valid = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      enc_reg <= '0;
    else
      enc_reg <= enc_next;
  end

  assign take_out = tick;
  assign sym_out = enc_reg.sym;
  assign sym_valid_out = enc_reg.valid;

  a_symbol_bits: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    sym_valid_out |-> sym_out == symbol_of(enc_reg.shreg, two_in))
    else $error("encoder symbol does not match register");
  a_branch_period: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    sym_valid_out |-> enc_reg.cnt == 13'h0000)
    else $error("symbol emitted off the branch period");
endmodule
`default_nettype wire

// ---- core_mem_model.sv ----
// core memory partner: word array, read window and list write-back check
// assumes the decoder marks each memory cycle with a one-clock start pulse
`timescale 1ns/100ps
`default_nettype none
module core_mem_model
  import fano_pkg::*;
(
  input wire logic clk_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire mem_word_t wdata_in,
  output var mem_word_t rdata_out
);
  mem_word_t mem [0:4095];
  mem_word_t last_reg = '0;
  logic [ADDR_W-1:0] addr_reg = '0;
  int phase_reg = 0;
  int valid_from = 1;
  int list_errs = 0;
  // data only inside the read window, inverted junk elsewhere
  always_comb
  begin
    if (phase_reg >= valid_from && phase_reg <= 3)
      rdata_out = mem[addr_reg];
    else
      rdata_out = ~last_reg;
  end
  always @(posedge clk_in)
  begin
    if (start_in)
    begin
      addr_reg <= addr_in;
      phase_reg <= 1;
    end
    else if (phase_reg != 0 && phase_reg < 7)
      phase_reg <= phase_reg + 1;
    else
      phase_reg <= 0;
    if (phase_reg == 3)
      last_reg <= mem[addr_reg];
    if (write_in)
    begin
      if (wdata_in.list !== mem[addr_in].list)
        list_errs <= list_errs + 1;
      mem[addr_in] <= wdata_in;
    end
  end
endmodule
`default_nettype wire

// ---- fano_decoder_core.sv ----
// sequential tree decoder core with its transmit encoder and register port
// assumes the core memory answers read data by the end of state b1
// Notes on behaviour
// - encoder is sixty stages with three parity sums of about thirty taps
// - symbol is four bits: one message plus three parity, or two plus two
// - encoder emits one branch symbol every 200 us
// - five selector inputs, two message and three parity, picked by rate
// - one branch per memory cycle; list is fetched mid cycle
// - metric formed in write interval; compare ends just after it
// - success steps address up one, failure down one, new cycle follows
// - write interval paths end with a new cycle; all but the alternate-branch path also change the address
// - at most one threshold raise per forward step
// - tightening check runs after the increment, on the node just reached
// - word is 28 list, 2 rank, 3 position, 2 message bits
// - branch rank needs two bits, at most four branches per node
// - word n holds list n, rank and position n-1, old message bits
// - list restored every cycle; path fields restored or rewritten
// - replica register matches the encoder and holds recent decisions
// - arithmetic adds the chosen metric to the sum and tests it
// - candidates use list message bits and replica parity
// - first matching position indexes metric table, else random off-list
// - non-negative sum is success, negative is failure
// - four equal states per computation cycle, started with memory
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fano_decoder_core
  import fano_pkg::*;
#(
  parameter int SYM_CYCLES = SYMBOL_CYCLES
)
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic RATE_TWO_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic [ADDR_W-1:0] MEM_ADDR_OUT,
  output logic MEM_START_OUT,
  output logic MEM_WRITE_OUT,
  output var mem_word_t MEM_WDATA_OUT,
  input wire mem_word_t MEM_RDATA_IN,
  input wire logic [1:0] ENC_MSG_IN,
  output logic ENC_TAKE_OUT,
  output logic [3:0] ENC_SYM_OUT,
  output logic ENC_SYM_VALID_OUT
);
  typedef struct packed {
    ctl_state_t st;
    logic [1:0] ph;
    logic [ADDR_W-1:0] n;
    logic signed [ACC_W-1:0] acc;
    logic [7:0] threshold_step;
    logic run;
    logic [7:0][7:0] tbl;
    mem_word_t word;
    logic [2:0] pos;
    logic [1:0] rank;
    logic [59:0] m;
    logic [1:0] m_out;
    logic [1:0] drop;
    logic [7:0] lambda;
    logic [2:0] jsel;
    logic [1:0] br;
    logic fwd;
    logic alt;
    logic prev_ok;
    logic tighten;
    mem_word_t wdata;
    logic [31:0] rdata;
    logic [7:0] lfsr;
  } core_t;

  core_t core_reg;
  core_t core_next;

  function automatic logic signed [ACC_W-1:0] sext(input logic [7:0] v);
    return {{(ACC_W - 8){v[7]}}, v};
  endfunction

  // smallest list position at or after start whose entry equals a generated branch
  function automatic logic [3:0] find_pos(input logic [27:0] y, input logic [59:0] m,
                                          input logic two, input logic [2:0] start);
    logic [3:0] hit;
    logic [3:0] b;
    hit = {1'b0, POS_OFF_LIST};
    for (int k = LIST_LEN - 1; k >= 0; k--)
    begin
      b = y[k*4 +: 4];
      if (3'(k) >= start && symbol_of(shift_fwd(m, b[3:2], two), two) == b)
        hit = {1'b1, 3'(k)};
    end
    return hit;
  endfunction

  logic ph_end;
  logic two;
  logic [1:0] last_rank;
  logic [2:0] start;
  logic [3:0] found;
  logic [2:0] pick;
  logic [1:0] pick_br;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] diff;
  logic ok;
  logic [59:0] m_right;
  logic [1:0] m_drop;
  logic [31:0] rd_val;

  assign two = RATE_TWO_IN;
  assign ph_end = core_reg.ph == PH_LAST;
  assign last_rank = two ? 2'h3 : 2'h1;
  assign start = !core_reg.alt ? 3'h0 :
                 core_reg.pos == POS_OFF_LIST ? POS_OFF_LIST : core_reg.pos + 3'h1;
  assign found = find_pos(core_reg.word.list, core_reg.m, two, start);
  assign pick = found[2:0];
  assign pick_br = found[3] ? core_reg.word.list[{found[2:0], 2'b10} +: 2] : core_reg.lfsr[1:0];
  assign sum = core_reg.acc + sext(core_reg.lambda);
  assign diff = core_reg.acc - sext(core_reg.tbl[core_reg.pos]);
  assign ok = !sum[ACC_W-1];
  assign m_right = two ? {2'b00, core_reg.m[59:2]} : {1'b0, core_reg.m[59:1]};
  assign m_drop = two ? core_reg.m[1:0] : {core_reg.m[0], 1'b0};

  always_comb
  begin
    case (ADDR_IN)
      REG_CTRL: rd_val = {31'h0000_0000, core_reg.run};
      REG_STEP: rd_val = {24'h00_0000, core_reg.threshold_step};
      REG_NODE: rd_val = {20'h0_0000, core_reg.n};
      REG_ACC: rd_val = 32'(core_reg.acc);
      default:
      begin
        if ((ADDR_IN & METRIC_MASK) == REG_METRIC && ADDR_IN[1:0] == 2'b00)
          rd_val = {24'h00_0000, core_reg.tbl[ADDR_IN[4:2]]};
        else
          rd_val = 32'h0000_0000;
      end
    endcase
  end

  always_comb
  begin
    core_next = core_reg;
    core_next.lfsr = {core_reg.lfsr[6:0],
                      core_reg.lfsr[7] ^ core_reg.lfsr[5] ^ core_reg.lfsr[4] ^ core_reg.lfsr[3]};
    core_next.rdata = RD_IN ? rd_val : 32'h0000_0000;
    if (WR_IN)
    begin
      if (ADDR_IN == REG_CTRL)
        core_next.run = WDATA_IN[CTRL_RUN_BIT];
      else if (ADDR_IN == REG_STEP)
        core_next.threshold_step = WDATA_IN[7:0];
      else if ((ADDR_IN & METRIC_MASK) == REG_METRIC && ADDR_IN[1:0] == 2'b00)
        core_next.tbl[ADDR_IN[4:2]] = WDATA_IN[7:0];
    end
    core_next.ph = (core_reg.st == ST_IDLE || ph_end) ? 2'h0 : core_reg.ph + 2'h1;
    case (core_reg.st)
      ST_IDLE:
      begin
        if (core_reg.run)
          core_next.st = ST_B0;
      end
      ST_B0:
      begin
        if (ph_end)
        begin
          core_next.st = ST_B1;
          // single raise: metric bound keeps one subtraction enough
          if (core_reg.tighten && core_reg.acc >= sext(core_reg.threshold_step))
            core_next.acc = core_reg.acc - sext(core_reg.threshold_step);
          core_next.tighten = 1'b0;
        end
      end
      ST_B1:
      begin
        if (ph_end)
        begin
          core_next.st = ST_B2;
          core_next.word = MEM_RDATA_IN;
          if (!core_reg.fwd)
            core_next.m[59:58] = MEM_RDATA_IN.msg;
        end
      end
      ST_B2:
      begin
        if (ph_end)
        begin
          core_next.st = ST_B3;
          core_next.jsel = pick;
          core_next.br = pick_br;
          core_next.lambda = core_reg.tbl[pick];
          core_next.wdata.list = core_reg.word.list;
          if (core_reg.prev_ok)
          begin
            core_next.wdata.msg = core_reg.m_out;
            core_next.wdata.pos = core_reg.pos;
            core_next.wdata.rank = core_reg.rank;
          end
          else
          begin
            core_next.wdata.msg = core_reg.word.msg;
            core_next.wdata.pos = core_reg.word.pos;
            core_next.wdata.rank = core_reg.word.rank;
          end
        end
      end
      ST_B3:
      begin
        if (ph_end)
        begin
          core_next.st = core_reg.run ? ST_B0 : ST_IDLE;
          core_next.alt = 1'b0;
          if (core_reg.fwd && ok)
          begin
            core_next.acc = sum;
            core_next.pos = core_reg.jsel;
            core_next.rank = core_reg.alt ? core_reg.rank + 2'h1 : 2'h0;
            core_next.m_out = two ? core_reg.m[59:58] : {core_reg.m[59], 1'b0};
            core_next.m = shift_fwd(core_reg.m, core_reg.br, two);
            core_next.n = core_reg.n + 12'h001;
            core_next.tighten = 1'b1;
            core_next.prev_ok = 1'b1;
          end
          else if (core_reg.fwd)
          begin
            core_next.drop = m_drop;
            core_next.m = m_right;
            core_next.n = core_reg.n - 12'h001;
            core_next.fwd = 1'b0;
            core_next.prev_ok = 1'b0;
          end
          else if (diff[ACC_W-1])
          begin
            // threshold lowered: the sum holds L-T, so adding the step lowers T
            core_next.acc = core_reg.acc + sext(core_reg.threshold_step);
            core_next.rank = 2'h0;
            core_next.m = shift_fwd(core_reg.m, core_reg.drop, two);
            core_next.n = core_reg.n + 12'h001;
            core_next.fwd = 1'b1;
            core_next.prev_ok = 1'b1;
          end
          else if (core_reg.rank == last_rank)
          begin
            core_next.acc = diff;
            core_next.pos = core_reg.word.pos;
            core_next.rank = core_reg.word.rank;
            core_next.drop = m_drop;
            core_next.m = m_right;
            core_next.n = core_reg.n - 12'h001;
            core_next.prev_ok = 1'b0;
          end
          else
          begin
            // alternate branch at this node: no address move
            core_next.acc = diff;
            core_next.fwd = 1'b1;
            core_next.alt = 1'b1;
            core_next.prev_ok = 1'b0;
          end
        end
      end
      default:
        core_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      core_reg <= '0;
      core_reg.st <= ST_IDLE;
      core_reg.threshold_step <= STEP_RESET;
      core_reg.fwd <= 1'b1;
      core_reg.lfsr <= 8'h01;
    end
    else
      core_reg <= core_next;
  end

  assign RDATA_OUT = core_reg.rdata;
  assign MEM_ADDR_OUT = core_reg.n;
  assign MEM_START_OUT = core_reg.st == ST_B0 && core_reg.ph == 2'h0;
  assign MEM_WRITE_OUT = core_reg.st == ST_B3 && core_reg.ph == 2'h0;
  assign MEM_WDATA_OUT = core_reg.wdata;

  conv_encoder #(
    .SYM_CYCLES(SYM_CYCLES)
  ) u_encoder (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .two_in(RATE_TWO_IN),
    .msg_in(ENC_MSG_IN),
    .take_out(ENC_TAKE_OUT),
    .sym_out(ENC_SYM_OUT),
    .sym_valid_out(ENC_SYM_VALID_OUT)
  );

  a_step_up: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    core_reg.st == ST_B3 && ph_end && core_reg.fwd && ok
      |=> MEM_ADDR_OUT == $past(MEM_ADDR_OUT) + 12'h001)
    else $error("success did not advance address");
  a_step_down: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    core_reg.st == ST_B3 && ph_end && core_reg.fwd && !ok
      |=> MEM_ADDR_OUT == $past(MEM_ADDR_OUT) - 12'h001)
    else $error("failure did not retreat address");
  a_state_length: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    $rose(core_reg.st == ST_B1) |-> (core_reg.st == ST_B1)[*2] ##1 core_reg.st == ST_B2)
    else $error("control state length wrong");
  a_cycle_span: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    MEM_START_OUT |-> ##6 MEM_WRITE_OUT ##2 (MEM_START_OUT || core_reg.st == ST_IDLE))
    else $error("memory cycle spacing wrong");
  a_list_restore: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    MEM_WRITE_OUT |-> MEM_WDATA_OUT.list == $past(MEM_RDATA_IN.list, 3))
    else $error("list section not restored");
  a_path_restore: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    MEM_WRITE_OUT && !core_reg.prev_ok
      |-> MEM_WDATA_OUT[34:28] == core_reg.word[34:28])
    else $error("path section not restored on failure cycle");
  a_single_raise: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    core_reg.tighten && core_reg.st == ST_B0 && ph_end |=> !core_reg.tighten)
    else $error("threshold raise pending too long");
  a_fail_keeps: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    core_reg.st == ST_B3 && ph_end && core_reg.fwd && sum < 0
      |=> core_reg.acc == $past(core_reg.acc) && core_reg.pos == $past(core_reg.pos))
    else $error("failure changed metric registers");
  a_replica_shift: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    core_reg.st == ST_B3 && ph_end && core_reg.fwd && ok && two
      |=> core_reg.m == {$past(core_reg.m[57:0]), $past(core_reg.br)})
    else $error("replica register not advanced by two");
endmodule
`default_nettype wire

// ---- fano_pkg.sv ----
// constants, types and shared encoder functions for the sequential decoder
// assumes a single 25 MHz machine clock
package fano_pkg;
  localparam int ENC_STAGES = 60;
  localparam int LIST_LEN = 7;
  localparam int ADDR_W = 12;
  localparam int ACC_W = 16;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYMBOL_TIME_NS = 200000;
  localparam int SYMBOL_CYCLES = SYMBOL_TIME_NS / CLK_PERIOD_NS;
  localparam int PHASE_CYCLES = 2;
  localparam logic [1:0] PH_LAST = 2'(PHASE_CYCLES - 1);
  localparam logic [2:0] POS_OFF_LIST = 3'h7;
  localparam logic [59:0] PAR_MASK_A = 60'hA5C_3E96_F12D_7B4C;
  localparam logic [59:0] PAR_MASK_B = 60'h6D2_B58E_39C4_A71E;
  localparam logic [59:0] PAR_MASK_C = 60'hC39_74A6_5EB1_1D6B;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STEP = 8'h04;
  localparam logic [7:0] REG_NODE = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0C;
  localparam logic [7:0] REG_METRIC = 8'h20;
  localparam logic [7:0] METRIC_MASK = 8'hE0;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [7:0] STEP_RESET = 8'h10;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_B0 = 5'b00010,
    ST_B1 = 5'b00100,
    ST_B2 = 5'b01000,
    ST_B3 = 5'b10000
  } ctl_state_t;

  typedef struct packed {
    logic [1:0] msg;
    logic [2:0] pos;
    logic [1:0] rank;
    logic [27:0] list;
  } mem_word_t;

  function automatic logic [59:0] shift_fwd(input logic [59:0] m, input logic [1:0] b,
                                            input logic two);
    return two ? {m[57:0], b} : {m[58:0], b[1]};
  endfunction

  function automatic logic [3:0] symbol_of(input logic [59:0] m, input logic two);
    logic p1;
    logic p2;
    logic p3;
    p1 = ^(m & PAR_MASK_A);
    p2 = ^(m & PAR_MASK_B);
    p3 = ^(m & PAR_MASK_C);
    return two ? {m[1], m[0], p1, p2} : {m[0], p1, p2, p3};
  endfunction
endpackage

// ---- tb.sv ----
// self-checking bench for the sequential decoder core
// assumes the core memory model answers inside its read window
`timescale 1ns/100ps
`default_nettype none
module tb
  import fano_pkg::*;
;
  localparam int SYM_N = 8;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rate_two = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic mem_start;
  logic mem_write;
  mem_word_t mem_wdata;
  mem_word_t mem_rdata;
  logic [1:0] enc_msg = 2'h0;
  logic enc_take;
  logic [3:0] enc_sym;
  logic enc_sym_valid;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;

  fano_decoder_core #(.SYM_CYCLES(SYM_N)) u_fano_decoder_core (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .RATE_TWO_IN(rate_two), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .MEM_ADDR_OUT(mem_addr), .MEM_START_OUT(mem_start), .MEM_WRITE_OUT(mem_write),
    .MEM_WDATA_OUT(mem_wdata), .MEM_RDATA_IN(mem_rdata), .ENC_MSG_IN(enc_msg),
    .ENC_TAKE_OUT(enc_take), .ENC_SYM_OUT(enc_sym), .ENC_SYM_VALID_OUT(enc_sym_valid));
  core_mem_model u_core_mem_model (
    .clk_in(clk), .addr_in(mem_addr), .start_in(mem_start), .write_in(mem_write),
    .wdata_in(mem_wdata), .rdata_out(mem_rdata));

  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(what, d, exp);
  endtask
  task automatic do_reset(input logic r);
    @(posedge clk);
    arst_n <= 1'b0;
    rate_two <= r;
    enc_msg <= 2'h0;
    for (int i = 0; i < 4096; i++)
      u_core_mem_model.mem[i] = {2'h0, 3'h0, 2'h3, 28'(i * 32'h0013_579B)};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
  endtask
  // follows one memory cycle from its start pulse to the next start slot
  task automatic watch_cycle(output logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    #1;
    while (mem_start !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("start_seen", 32'(mem_start), 32'h1);
    a = mem_addr;
    for (int k = 1; k < 8; k++)
    begin
      @(posedge clk);
      #1;
      chk("write_slot", 32'(mem_write), 32'(k == 6));
      chk("addr_hold", 32'(mem_addr), 32'(a));
    end
    @(posedge clk);
  endtask

  task automatic t_encoder();
    logic [59:0] m;
    logic [1:0] b;
    logic [3:0] exp;
    int n;
    int last;
    m = '0;
    last = 0;
    for (int i = 0; i < 6; i++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        #1;
        n++;
      end while (enc_take !== 1'b1 && n < 20);
      if (i > 0)
        chk("enc_period", 32'(cyc - last), 32'(SYM_N));
      last = cyc;
      b = enc_msg;
      @(posedge clk);
      enc_msg <= 2'(i * 3 + 1);
      if (rate_two)
      begin
        m = {m[57:0], b};
        exp = {b, ^(m & PAR_MASK_A), ^(m & PAR_MASK_B)};
      end
      else
      begin
        m = {m[58:0], b[1]};
        exp = {b[1], ^(m & PAR_MASK_A), ^(m & PAR_MASK_B), ^(m & PAR_MASK_C)};
      end
      #1;
      chk("enc_valid", 32'(enc_sym_valid), 32'h1);
      chk("enc_sym", 32'(enc_sym), 32'(exp));
      chk("enc_msg_pos", 32'(rate_two ? enc_sym[3:2] : {1'b0, enc_sym[3]}),
          32'(rate_two ? b : {1'b0, b[1]}));
      @(posedge clk);
      #1;
      chk("enc_valid_end", 32'(enc_sym_valid), 32'h0);
    end
  endtask

  task automatic t_regs();
    chk_rd("ctrl", REG_CTRL, 32'h0000_0000);
    chk_rd("step", REG_STEP, 32'(STEP_RESET));
    chk_rd("node", REG_NODE, 32'h0000_0000);
    chk_rd("acc", REG_ACC, 32'h0000_0000);
    chk_rd("unmapped", 8'h40, 32'h0000_0000);
    for (int k = 0; k < 8; k++)
      bus_wr(REG_METRIC + 8'(4 * k), 32'(k + 1));
    bus_wr(REG_NODE, 32'h0000_0123);
    bus_wr(8'h44, 32'hFFFF_FFFF);
    for (int k = 0; k < 8; k++)
      chk_rd("metric", REG_METRIC + 8'(4 * k), 32'(k + 1));
    chk_rd("node_ro", REG_NODE, 32'h0000_0000);
    chk_rd("unmapped_wr", 8'h44, 32'h0000_0000);
    @(posedge clk);
    #1;
    chk("rdata_idle", rdata, 32'h0000_0000);
  endtask

  task automatic t_forward(input int steps);
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] a0;
    logic [ADDR_W-1:0] prev;
    logic [31:0] d;
    for (int k = 0; k < 8; k++)
      bus_wr(REG_METRIC + 8'(4 * k), 32'h0000_0003);
    bus_wr(REG_CTRL, 32'h0000_0001);
    watch_cycle(prev);
    a0 = prev;
    for (int i = 0; i < steps; i++)
    begin
      watch_cycle(a);
      chk("addr_up", 32'(a), 32'(prev + 12'h001));
      prev = a;
    end
    bus_wr(REG_CTRL, 32'h0000_0000);
    repeat (16) @(posedge clk);
    #1;
    chk("idle", 32'(mem_start), 32'h0);
    bus_rd(REG_NODE, d);
    chk("node_idx", d, 32'(prev + 12'h002));
    bus_rd(REG_ACC, d);
    chk("acc_span", 32'($signed(d) >= 0 && $signed(d) < 19), 32'h1);
    for (int i = a0 + 1; i <= prev + 1; i++)
      chk("rank_span", 32'(u_core_mem_model.mem[i].rank <= (rate_two ? 2'h3 : 2'h1)),
          32'h1);
    chk("list_kept", 32'(u_core_mem_model.list_errs), 32'h0);
  endtask

  task automatic t_backward();
    logic [31:0] d;
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] b;
    mem_word_t w;
    for (int k = 0; k < 8; k++)
      bus_wr(REG_METRIC + 8'(4 * k), 32'h0000_00C0);
    bus_rd(REG_NODE, d);
    w = u_core_mem_model.mem[d[ADDR_W-1:0] - 12'h001];
    bus_wr(REG_CTRL, 32'h0000_0001);
    watch_cycle(a);
    chk("resume_addr", 32'(a), d);
    watch_cycle(b);
    chk("addr_down", 32'(b), 32'(a - 12'h001));
    chk("h_restore", 32'(u_core_mem_model.mem[b][34:28]), 32'(w[34:28]));
    bus_wr(REG_CTRL, 32'h0000_0000);
    repeat (24) @(posedge clk);
  endtask

  initial
  begin
    do_reset(1'b0);
    t_encoder();
    t_regs();
    t_forward(6);
    t_backward();
    u_core_mem_model.valid_from = 3;
    do_reset(1'b1);
    t_encoder();
    t_forward(4);
    close_out();
  end
endmodule
`default_nettype wire
